// ==== include/fir_flash_consts.vh ====
// constants of the flash access and in-situ programming block
//
// Functional notes
// - flash is one array of bytes
// - byte writes, up to sixteen per operation
// - array sits at top of address space
// - select pin held high plus entry key byte on the data line enters programming mode
// - order: RAM mode, download, then execute
// - link uses reset, serial clock, data, select
// - oscillator kept running while programming
// - protection taken from non-volatile option bit
// - protection blocks external reads and rewrites
// - unprotecting erases whole array first
`ifndef FIR_FLASH_CONSTS_VH
`define FIR_FLASH_CONSTS_VH

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define FIR_ADDR_W       13
`define FIR_DEPTH        8192
`define FIR_LAST_ADDR    13'h1FFF
`define FIR_TOP_BITS     3'h7
`define FIR_ROW_BYTES    16
`define FIR_ERASED_BYTE  8'hFF

// ----------------------------------------------------------------
// programming link
// ----------------------------------------------------------------
`define FIR_ENTRY_KEY    8'hA5
`define FIR_BYTE_BITS    3'h7

// ----------------------------------------------------------------
// link state codes, one-hot
// ----------------------------------------------------------------
`define FIR_ST_IDLE      4'h1
`define FIR_ST_KEY       4'h2
`define FIR_ST_LEN       4'h4
`define FIR_ST_LOAD      4'h8

`endif

// ==== logic/fir_flash_isp.v ====
// flash access, protection and in-situ programming control
`timescale 1ns/1ps
`default_nettype none
`include "fir_flash_consts.vh"

module fir_flash_isp
(
  // clock and reset
  input  wire        i_clk,
  input  wire        i_resetn,
  // programming link pins
  input  wire        i_prog_mode_select_pin,
  input  wire        i_prog_serial_clock,
  input  wire        i_prog_serial_data_in,
  // non-volatile option
  input  wire        i_opt_protect,
  input  wire        i_opt_unprotect_req,
  // cpu flash access
  input  wire [15:0] i_cpu_addr,
  input  wire        i_cpu_rd,
  input  wire        i_cpu_wr,
  input  wire [7:0]  i_cpu_wdata,
  input  wire        i_cpu_prog_go,
  output reg  [7:0]  o_cpu_rdata,
  output reg         o_cpu_rvalid,
  output wire        o_prog_busy,
  output reg         o_prog_err,
  // programming session
  output wire        o_ram_exec_mode,
  output wire        o_ram_run,
  output reg         o_dl_valid,
  output reg  [7:0]  o_dl_data,
  output reg  [7:0]  o_dl_addr,
  output wire        o_osc_keep_on,
  // protection state
  output wire        o_protected,
  output wire        o_erase_busy
);

  // ----------------------------------------------------------------
  // pin synchronisers and filtered levels
  // ----------------------------------------------------------------
  reg [2:0] sync1_ff;
  reg [2:0] sync2_ff;
  reg [2:0] sync3_ff;
  reg [2:0] flt_ff;
  wire [2:0] pins = {i_prog_mode_select_pin, i_prog_serial_clock, i_prog_serial_data_in};
  wire [2:0] agree = ~(sync2_ff ^ sync3_ff);
  wire [2:0] nxt_flt = (agree & sync2_ff) | (~agree & flt_ff);

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sync3_ff <= 3'h0;
      flt_ff   <= 3'h0;
    end
    else
    begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      flt_ff   <= nxt_flt;
    end
  end

  wire sel_lvl  = flt_ff[2];
  wire sck_rise = nxt_flt[1] & ~flt_ff[1];
  wire sdi_lvl  = nxt_flt[0];

  // ----------------------------------------------------------------
  // serial byte assembly
  // ----------------------------------------------------------------
  reg  [3:0] st_ff;
  reg  [7:0] shift_ff;
  reg  [2:0] bit_ff;
  wire       byte_done = sck_rise & (bit_ff == `FIR_BYTE_BITS);
  wire [7:0] byte_val  = {shift_ff[6:0], sdi_lvl};

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      shift_ff <= 8'h00;
      bit_ff   <= 3'h0;
    end
    else if (st_ff == `FIR_ST_IDLE || !sel_lvl)
    begin
      shift_ff <= 8'h00;
      bit_ff   <= 3'h0;
    end
    else if (sck_rise)
    begin
      shift_ff <= byte_val;
      bit_ff   <= bit_ff + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // programming session state machine
  // ----------------------------------------------------------------
  reg       run_ff;
  reg [7:0] len_ff;

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_ff      <= `FIR_ST_IDLE;
      run_ff     <= 1'b0;
      len_ff     <= 8'h00;
      o_dl_valid <= 1'b0;
      o_dl_data  <= 8'h00;
      o_dl_addr  <= 8'h00;
    end
    else
    begin
      o_dl_valid <= 1'b0;
      if (!sel_lvl)
      begin
        st_ff  <= `FIR_ST_IDLE;
        run_ff <= 1'b0;
      end
      else
      begin
        case (st_ff)
          `FIR_ST_IDLE:
          begin
            if (!run_ff)
              st_ff <= `FIR_ST_KEY;
          end
          `FIR_ST_KEY:
          begin
            if (byte_done)
            begin
              if (byte_val == `FIR_ENTRY_KEY)
                st_ff <= `FIR_ST_LEN;
              else
                st_ff <= `FIR_ST_IDLE;
              run_ff <= 1'b1;
            end
          end
          `FIR_ST_LEN:
          begin
            if (byte_done)
            begin
              len_ff    <= byte_val;
              o_dl_addr <= 8'hFF;
              st_ff     <= `FIR_ST_LOAD;
            end
          end
          `FIR_ST_LOAD:
          begin
            if (byte_done)
            begin
              o_dl_valid <= 1'b1;
              o_dl_data  <= byte_val;
              o_dl_addr  <= o_dl_addr + 8'h01;
              if (o_dl_addr + 8'h01 == len_ff - 8'h01)
                st_ff <= `FIR_ST_IDLE;
            end
          end
          default:
            st_ff <= `FIR_ST_IDLE;
        endcase
      end
    end
  end

  // run_ff marks a session: idle with run_ff set means executing or a rejected key byte
  wire in_session = (st_ff != `FIR_ST_IDLE) | run_ff;
  wire key_ok     = (st_ff == `FIR_ST_LEN) | (st_ff == `FIR_ST_LOAD);
  reg  exec_ff;

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      exec_ff <= 1'b0;
    else if (!sel_lvl)
      exec_ff <= 1'b0;
    else if (st_ff == `FIR_ST_LOAD && byte_done && o_dl_addr + 8'h01 == len_ff - 8'h01)
      exec_ff <= 1'b1;
  end

  assign o_ram_exec_mode = key_ok | exec_ff;
  assign o_ram_run       = exec_ff;
  assign o_osc_keep_on   = in_session;

  // ----------------------------------------------------------------
  // protection option and full erase
  // ----------------------------------------------------------------
  reg                   prot_ff;
  reg                   cap_ff;
  reg                   erase_ff;
  reg [`FIR_ADDR_W-1:0] ecnt_ff;

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      prot_ff  <= 1'b1;
      cap_ff   <= 1'b0;
      erase_ff <= 1'b0;
      ecnt_ff  <= {`FIR_ADDR_W{1'b0}};
    end
    else if (!cap_ff)
    begin
      cap_ff  <= 1'b1;
      prot_ff <= i_opt_protect;
    end
    else if (erase_ff)
    begin
      ecnt_ff <= ecnt_ff + 1'b1;
      if (ecnt_ff == `FIR_LAST_ADDR)
      begin
        erase_ff <= 1'b0;
        prot_ff  <= 1'b0;
      end
    end
    else if (i_opt_unprotect_req && prot_ff)
    begin
      erase_ff <= 1'b1;
      ecnt_ff  <= {`FIR_ADDR_W{1'b0}};
    end
  end

  assign o_protected  = prot_ff | ~cap_ff;
  assign o_erase_busy = erase_ff;

  // ----------------------------------------------------------------
  // sixteen-byte row buffer and programming walk
  // ----------------------------------------------------------------
  // array decodes top of space
  wire        hit = (i_cpu_addr[15:13] == `FIR_TOP_BITS);
  reg  [7:0]  row_ff [0:`FIR_ROW_BYTES-1];
  reg  [15:0] mask_ff;
  reg  [8:0]  rowa_ff;
  reg         pbusy_ff;
  reg  [3:0]  pidx_ff;
  wire        same_row = (mask_ff == 16'h0000) | (rowa_ff == i_cpu_addr[12:4]);
  wire        locked   = o_protected | erase_ff;

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mask_ff    <= 16'h0000;
      rowa_ff    <= 9'h000;
      pbusy_ff   <= 1'b0;
      pidx_ff    <= 4'h0;
      o_prog_err <= 1'b0;
    end
    else
    begin
      o_prog_err <= 1'b0;
      if (pbusy_ff)
      begin
        pidx_ff <= pidx_ff + 4'h1;
        if (pidx_ff == 4'hF)
        begin
          pbusy_ff <= 1'b0;
          mask_ff  <= 16'h0000;
        end
      end
      else if (i_cpu_prog_go)
      begin
        if (locked)
        begin
          o_prog_err <= 1'b1;
          mask_ff    <= 16'h0000;
        end
        else if (mask_ff != 16'h0000)
        begin
          pbusy_ff <= 1'b1;
          pidx_ff  <= 4'h0;
        end
      end
      else if (i_cpu_wr && hit)
      begin
        if (same_row)
        begin
          rowa_ff                <= i_cpu_addr[12:4];
          mask_ff[i_cpu_addr[3:0]] <= 1'b1;
        end
        else
          o_prog_err <= 1'b1;
      end
    end
  end

  always @(posedge i_clk)
  begin
    if (!pbusy_ff && !i_cpu_prog_go && i_cpu_wr && hit && same_row)
      row_ff[i_cpu_addr[3:0]] <= i_cpu_wdata;
  end

  assign o_prog_busy = pbusy_ff;

  // ----------------------------------------------------------------
  // array port arbitration and read path
  // ----------------------------------------------------------------
  wire                   m_we    = erase_ff | (pbusy_ff & mask_ff[pidx_ff]);
  wire [`FIR_ADDR_W-1:0] m_addr  = erase_ff ? ecnt_ff :
                                   pbusy_ff ? {rowa_ff, pidx_ff} : i_cpu_addr[12:0];
  wire [7:0]             m_wdata = erase_ff ? `FIR_ERASED_BYTE : row_ff[pidx_ff];
  wire [7:0]             m_q;

  fir_flash_mem u_mem
  (
    .i_clk   (i_clk),
    .i_we    (m_we),
    .i_addr  (m_addr),
    .i_wdata (m_wdata),
    .o_rdata (m_q)
  );

  reg pend_ff;
  reg blk_ff;

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pend_ff      <= 1'b0;
      blk_ff       <= 1'b0;
      o_cpu_rvalid <= 1'b0;
      o_cpu_rdata  <= 8'h00;
    end
    else
    begin
      pend_ff      <= i_cpu_rd & hit & ~pbusy_ff & ~erase_ff;
      blk_ff       <= (o_protected & o_ram_exec_mode) | erase_ff;
      o_cpu_rvalid <= pend_ff;
      o_cpu_rdata  <= (pend_ff && !blk_ff) ? m_q : 8'h00;
    end
  end

endmodule
`default_nettype wire

// ==== logic/fir_flash_mem.v ====
// byte-wide flash array with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "fir_flash_consts.vh"

module fir_flash_mem
(
  // clock
  input  wire                   i_clk,
  // access port
  input  wire                   i_we,
  input  wire [`FIR_ADDR_W-1:0] i_addr,
  input  wire [7:0]             i_wdata,
  output reg  [7:0]             o_rdata
);

  reg [7:0] mem_ff [0:`FIR_DEPTH-1];

  // ----------------------------------------------------------------
  // single port, read each edge, write as well when i_we is set
  // ----------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_we)
      mem_ff[i_addr] <= i_wdata;
    o_rdata <= mem_ff[i_addr];
  end

endmodule
`default_nettype wire

// ==== verif/fir_flash_isp_monitor.sv ====
// checker for the flash access and programming block
`timescale 1ns/1ps
`default_nettype none
module fir_flash_isp_monitor
(
  // clock, reset and inputs
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_prog_mode_select_pin,
  input wire logic        i_opt_unprotect_req,
  input wire logic [15:0] i_cpu_addr,
  input wire logic        i_cpu_rd,
  // outputs
  input wire logic [7:0]  o_cpu_rdata,
  input wire logic        o_cpu_rvalid,
  input wire logic        o_prog_busy,
  input wire logic        o_erase_busy,
  input wire logic        o_protected,
  input wire logic        o_ram_exec_mode,
  input wire logic        o_ram_run,
  input wire logic        o_osc_keep_on,
  input wire logic        o_dl_valid
);
  logic [13:0] run_cnt_ff;
  // length of the current busy stretch
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      run_cnt_ff <= 14'h0000;
    else if (o_prog_busy || o_erase_busy)
      run_cnt_ff <= run_cnt_ff + 14'h0001;
    else
      run_cnt_ff <= 14'h0000;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_mode_needs_select: assert property (!i_prog_mode_select_pin [*6] |-> !o_ram_exec_mode && !o_ram_run)
    else $error("session open without select");
  a_run_after_mode: assert property (o_ram_run |-> o_ram_exec_mode)
    else $error("run without ram mode");
  a_osc_in_session: assert property (o_ram_exec_mode |-> o_osc_keep_on)
    else $error("oscillator not kept");
  a_dl_single: assert property (o_dl_valid |=> !o_dl_valid)
    else $error("download pulse too long");
  a_read_blocked: assert property (i_cpu_rd && i_cpu_addr[15:13] == 3'h7 && o_protected && o_ram_exec_mode
    && !o_erase_busy |-> ##[1:3] (o_cpu_rvalid && o_cpu_rdata == 8'h00))
    else $error("protected read leaked");
  a_no_write_prot: assert property ($rose(o_prog_busy) |-> !o_protected)
    else $error("write while protected");
  a_prog_len: assert property ($fell(o_prog_busy) |-> run_cnt_ff == 14'h0010)
    else $error("program length wrong");
  a_erase_len: assert property ($fell(o_erase_busy) |-> run_cnt_ff == 14'h2000 && !o_protected)
    else $error("erase length wrong");
  c_erase: cover property ($fell(o_erase_busy));
  c_run: cover property ($rose(o_ram_run));
  c_prog: cover property ($fell(o_prog_busy));
endmodule
bind fir_flash_isp fir_flash_isp_monitor u_mon (.i_clk, .i_resetn, .i_prog_mode_select_pin,
  .i_opt_unprotect_req, .i_cpu_addr, .i_cpu_rd, .o_cpu_rdata, .o_cpu_rvalid, .o_prog_busy,
  .o_erase_busy, .o_protected, .o_ram_exec_mode, .o_ram_run, .o_osc_keep_on, .o_dl_valid);
`default_nettype wire

// ==== verif/fir_flash_isp_tb.sv ====
// self-checking bench for the flash access block
`timescale 1ns/1ps
`default_nettype none
module fir_flash_isp_tb;
  logic i_clk, i_resetn, i_opt_protect, i_opt_unprotect_req;
  logic i_cpu_rd, i_cpu_wr, i_cpu_prog_go;
  logic [15:0] i_cpu_addr;
  logic [7:0] i_cpu_wdata, dl_last;
  wire logic sel, sclk, sdata, o_cpu_rvalid, o_prog_busy, o_prog_err, o_ram_exec_mode, o_ram_run;
  wire logic o_dl_valid, o_osc_keep_on, o_protected, o_erase_busy;
  wire logic [7:0] o_cpu_rdata, o_dl_data, o_dl_addr;
  int err_total = 0, checks_done = 0, cycles = 0, dl_cnt = 0;
  always #2 i_clk = ~i_clk;
  fir_tool_model tool (.o_sel(sel), .o_sclk(sclk), .o_sdata(sdata));
  fir_flash_isp uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_prog_mode_select_pin(sel),
    .i_prog_serial_clock(sclk), .i_prog_serial_data_in(sdata), .i_opt_protect(i_opt_protect),
    .i_opt_unprotect_req(i_opt_unprotect_req), .i_cpu_addr(i_cpu_addr), .i_cpu_rd(i_cpu_rd),
    .i_cpu_wr(i_cpu_wr), .i_cpu_wdata(i_cpu_wdata), .i_cpu_prog_go(i_cpu_prog_go),
    .o_cpu_rdata(o_cpu_rdata), .o_cpu_rvalid(o_cpu_rvalid), .o_prog_busy(o_prog_busy),
    .o_prog_err(o_prog_err), .o_ram_exec_mode(o_ram_exec_mode), .o_ram_run(o_ram_run),
    .o_dl_valid(o_dl_valid), .o_dl_data(o_dl_data), .o_dl_addr(o_dl_addr),
    .o_osc_keep_on(o_osc_keep_on), .o_protected(o_protected), .o_erase_busy(o_erase_busy));
  task chk(input bit ok, input string msg);
    checks_done++;
    if (!ok)
    begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] exp);
    i_cpu_addr = a;
    i_cpu_rd = 1'b1;
    tick(1);
    i_cpu_rd = 1'b0;
    for (int k = 0; k < 4 && o_cpu_rvalid !== 1'b1; k++)
      tick(1);
    chk(o_cpu_rvalid === 1'b1 && o_cpu_rdata === exp, "read data");
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    i_cpu_addr = a;
    i_cpu_wdata = d;
    i_cpu_wr = 1'b1;
    tick(1);
    i_cpu_wr = 1'b0;
  endtask
  task go_err(input logic exp);
    for (int k = 0; k < 3 && o_prog_err !== 1'b1; k++)
      tick(1);
    chk(o_prog_err === exp, "program error flag");
  endtask
  task t_locked;
    wr(16'hE000, 8'h12);
    i_cpu_prog_go = 1'b1;
    tick(1);
    i_cpu_prog_go = 1'b0;
    go_err(1'b1);
    $display("locked done");
  endtask
  task t_session;
    tool.set_sel(1'b1);
    tool.send_byte(8'hA5);
    tick(8);
    chk(o_ram_exec_mode === 1'b1 && o_osc_keep_on === 1'b1, "key");
    rd(16'hFFFE, 8'h00);
    tool.send_byte(8'h02);
    tool.send_byte(8'h11);
    tool.send_byte(8'h22);
    tick(8);
    chk(dl_cnt == 2 && dl_last === 8'h22 && o_dl_addr === 8'h01 && o_ram_run === 1'b1, "run");
    tool.set_sel(1'b0);
    chk(o_ram_exec_mode === 1'b0 && o_ram_run === 1'b0 && o_osc_keep_on === 1'b0, "closed");
    tool.set_sel(1'b1);
    tool.send_byte(8'h5A);
    tool.send_byte(8'hA5);
    tick(8);
    chk(o_ram_exec_mode === 1'b0, "wrong key");
    tool.set_sel(1'b0);
    $display("session done");
  endtask
  task t_erase;
    i_opt_unprotect_req = 1'b1;
    tick(1);
    i_opt_unprotect_req = 1'b0;
    chk(o_erase_busy === 1'b1 && o_protected === 1'b1, "erase started");
    for (int k = 0; k < 9000 && o_erase_busy !== 1'b0; k++)
      tick(1);
    chk(o_protected === 1'b0 && o_erase_busy === 1'b0, "unprotected");
    rd(16'hE000, 8'hFF);
    rd(16'hFFFF, 8'hFF);
    $display("erase done");
  endtask
  task t_program;
    for (int i = 0; i < 16; i++)
    begin
      wr(16'hE000 + 16'(i), 8'h40 + 8'(i));
      tick(1);
    end
    i_cpu_prog_go = 1'b1;
    tick(1);
    i_cpu_prog_go = 1'b0;
    tick(1);
    chk(o_prog_busy === 1'b1, "busy");
    for (int k = 0; k < 40 && o_prog_busy !== 1'b0; k++)
      tick(1);
    rd(16'hE000, 8'h40);
    rd(16'hE00F, 8'h4F);
    wr(16'hE010, 8'h01);
    tick(1);
    wr(16'hE020, 8'h02);
    go_err(1'b1);
    $display("program done");
  endtask
  task t_reopt;
    i_resetn = 1'b0;
    i_opt_protect = 1'b0;
    tick(2);
    chk(o_protected === 1'b1 && o_prog_busy === 1'b0 && o_ram_run === 1'b0, "reset state");
    i_resetn = 1'b1;
    tick(2);
    chk(o_protected === 1'b0, "option clear taken");
    rd(16'hE001, 8'h41);
    $display("reopt done");
  endtask
  initial
  begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    i_opt_protect = 1'b1;
    i_opt_unprotect_req = 1'b0;
    i_cpu_rd = 1'b0;
    i_cpu_wr = 1'b0;
    i_cpu_prog_go = 1'b0;
    i_cpu_addr = 16'hE000;
    i_cpu_wdata = 8'h00;
    tick(2);
    chk(o_protected === 1'b1, "reset level");
    i_resetn = 1'b1;
    tick(2);
    chk(o_protected === 1'b1, "option taken");
    t_locked;
    t_session;
    t_erase;
    t_program;
    t_reopt;
    stop_test;
  end
  always @(posedge i_clk)
  begin
    cycles++;
    if (o_dl_valid === 1'b1)
    begin
      dl_cnt++;
      dl_last = o_dl_data;
    end
    if (cycles == 30000)
    begin
      err_total++;
      stop_test;
    end
  end
endmodule
`default_nettype wire

// ==== verif/fir_tool_model.sv ====
// behavioural programming tool driving the link pins
`timescale 1ns/1ps
`default_nettype none
module fir_tool_model
(
  // link pins
  output var logic o_sel,
  output var logic o_sclk,
  output var logic o_sdata
);
  initial
  begin
    o_sel = 1'b0;
    o_sclk = 1'b0;
    o_sdata = 1'b1;
  end
  task set_sel(input logic v);
    o_sel = v;
    #400;
  endtask
  task send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      o_sdata = b[i];
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
    // released line shows inverse
    o_sdata = ~b[0];
  endtask
endmodule
`default_nettype wire
